// ### cio_pkg.sv
// shared constants, types and helper functions for the channel-side tag controller
package cio_pkg;

    // ********************************************************
    // clock and timing
    // ********************************************************
    localparam int CLK_PERIOD_NS = 20;   // ref_clk period, 50 mhz
    localparam int OUT_LEAD_NS   = 100;  // outbound data ahead of its tag
    localparam int IN_SETTLE_NS  = 100;  // inbound data valid after its tag
    localparam int ADR_SETUP_NS  = 250;  // address and live ahead of address tag
    localparam int ADR_GAP_NS    = 250;  // address tag low time before a rise
    localparam int POLL_DLY_NS   = 400;  // address tag ahead of poll output

    // least times round up to whole cycles
    localparam int OUT_LEAD_CYC  = (OUT_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int IN_SETTLE_CYC = (IN_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ADR_SETUP_CYC = (ADR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ADR_GAP_CYC   = (ADR_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int POLL_DLY_CYC  = (POLL_DLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int CNT_W = 5;                               // delay counter width
    localparam logic [CNT_W-1:0] CNT_MAX = 5'h1f;           // counter saturation value

    // ********************************************************
    // data path
    // ********************************************************
    localparam int BYTE_W     = 8;    // information bits per lane
    localparam int FIFO_DEPTH = 32;   // outbound write data buffer depth
    localparam logic [8:0] BUS_IDLE = 9'h100;  // all-zero byte with odd parity

    // ********************************************************
    // pin and user bundles
    // ********************************************************
    typedef struct packed {
        logic [8:0] bus;       // outbound lane, bit 8 parity, bit 7 position 0
        logic       live;      // channel live line
        logic       adr;       // outbound address tag
        logic       cmd;       // outbound command tag
        logic       svc;       // outbound service tag
        logic       poll;      // selection poll output
        logic       hold;      // hold output
        logic       supp;      // status suppress line
    } cio_out_s;

    typedef struct packed {
        logic [8:0] bus;       // inbound lane, bit 8 parity
        logic       dev_sel;   // selected line
        logic       adr;       // inbound address tag
        logic       sta;       // inbound status tag
        logic       svc;       // inbound service tag
        logic       poll_ret;  // poll return
        logic       req;       // wired-or service request
    } cio_in_s;

    typedef struct packed {
        logic [7:0] addr;      // device address to select
        logic [7:0] cmd;       // command byte
        logic       write;     // 1: service bytes come from the fifo
    } cio_req_s;

    typedef enum logic [2:0] {
        EV_ADDR  = 3'h0,       // selected address echoed by the device
        EV_STAT  = 3'h1,       // status byte taken
        EV_READ  = 3'h2,       // read or sense byte taken
        EV_BUSY  = 3'h3,       // quick busy reply status
        EV_NODEV = 3'h4,       // poll returned, nobody answered
        EV_END   = 3'h5        // selected line dropped, sequence over
    } cio_evt_e;

    typedef struct packed {
        cio_evt_e   code;      // kind of event
        logic [7:0] data;      // byte taken from the inbound lane
        logic       perr;      // inbound byte had even parity
    } cio_evt_s;

    typedef enum logic [3:0] {
        ST_IDLE     = 4'h0,
        ST_ADR_SET  = 4'h1,
        ST_ADR_UP   = 4'h2,
        ST_POLL     = 4'h3,
        ST_SELECTED = 4'h4,
        ST_SETTLE   = 4'h5,
        ST_FETCH    = 4'h6,
        ST_LEAD     = 4'h7,
        ST_HOLD     = 4'h8,
        ST_QB_WAIT  = 4'h9
    } cio_state_e;

    // ********************************************************
    // helpers
    // ********************************************************
    // attach odd parity to a byte
    function automatic logic [8:0] cio_par(input logic [7:0] b);
        return {~(^b), b};
    endfunction : cio_par

    // saturating increment of a delay counter
    function automatic logic [CNT_W-1:0] cio_inc(input logic [CNT_W-1:0] c);
        return (c == CNT_MAX) ? c : c + 5'h01;
    endfunction : cio_inc

endpackage : cio_pkg

// ### cio_fifo.sv
// flip-flop fifo with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module cio_fifo
    import cio_pkg::*;
#(
    parameter int W = BYTE_W,
    parameter int D = FIFO_DEPTH
) (
    input  wire logic         ref_clk,
    input  wire logic         sys_rst,
    input  wire logic [W-1:0] in_data,
    input  wire logic         in_valid,
    output var  logic         in_ready,
    output var  logic [W-1:0] out_data,
    output var  logic         out_valid,
    input  wire logic         out_ready
);
    localparam int AW = $clog2(D);

    // ********************************************************
    // storage and pointers
    // ********************************************************
    logic [W-1:0] mem_r [D];             // storage words
    logic [AW-1:0] wp_r, wp_nxt;         // write index
    logic [AW-1:0] rp_r, rp_nxt;         // read index
    logic [AW:0]   cnt_r, cnt_nxt;       // words held
    logic          rdy_r, rdy_nxt;       // registered not-full
    logic          push, pop;

    // next pointers and count
    always_comb begin
        push    = in_valid && rdy_r;
        pop     = out_ready && (cnt_r != '0);
        wp_nxt  = push ? AW'(wp_r + 1'b1) : wp_r;
        rp_nxt  = pop ? AW'(rp_r + 1'b1) : rp_r;
        cnt_nxt = AW'(0) + cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        rdy_nxt = (cnt_nxt != (AW+1)'(D));
    end

    // register pointers and words
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
            rdy_r <= 1'b0;
        end else begin
            wp_r  <= wp_nxt;
            rp_r  <= rp_nxt;
            cnt_r <= cnt_nxt;
            rdy_r <= rdy_nxt;
        end
        if (push) begin
            mem_r[wp_r] <= in_data;
        end
    end

    assign in_ready  = rdy_r;
    assign out_valid = (cnt_r != '0);
    assign out_data  = mem_r[rp_r];
endmodule : cio_fifo
`default_nettype wire

// ### cio_chan_ctl.sv
// channel-side controller driving the byte-wide tagged i/o interface
`timescale 1ns/10ps
`default_nettype none
module cio_chan_ctl
    import cio_pkg::*;
(
    input  wire logic            ref_clk,
    input  wire logic            sys_rst,
    input  wire logic            live_en,
    input  wire logic            supp_en,
    input  wire cio_req_s        req,
    input  wire logic            req_valid,
    output var  logic            req_ready,
    input  wire logic            req_cancel,
    input  wire logic [7:0]      wr_data,
    input  wire logic            wr_valid,
    output var  logic            wr_ready,
    output var  cio_evt_s        evt,
    output var  logic            evt_valid,
    output var  logic            svc_req,
    input  wire cio_in_s         pin_in,
    output var  cio_out_s        pin_out
);
    // ********************************************************
    // declarations
    // ********************************************************
    cio_in_s    s1_r, si_r;               // two-stage pin synchroniser
    cio_state_e st_r, st_nxt;             // sequence state
    cio_out_s   po_r, po_nxt;             // registered pin outputs
    logic [CNT_W-1:0] cnt_r, cnt_nxt;     // delay down-counter
    logic [CNT_W-1:0] gap_r, gap_nxt;     // cycles address tag has been low
    logic [CNT_W-1:0] lv_r, lv_nxt;       // cycles live has been up
    logic [CNT_W-1:0] stab_r, stab_nxt;   // cycles outbound lane unchanged
    cio_evt_e   kind_r, kind_nxt;         // inbound tag being served
    logic       wr_r, wr_nxt;             // current sequence writes
    logic [7:0] cmd_r, cmd_nxt;           // command for this sequence
    cio_evt_s   evt_r, evt_nxt;           // event to user
    logic       ev_r, ev_nxt;             // event strobe
    logic       rdy_r, rdy_nxt;           // request acceptance
    logic       quiet;                    // selection lines all low
    logic [7:0] fifo_data;
    logic       fifo_valid, fifo_pop, fifo_in_ready;

    // ********************************************************
    // write data buffer
    // ********************************************************
    cio_fifo #(.W(BYTE_W), .D(FIFO_DEPTH)) u_fifo (
        .ref_clk   (ref_clk),
        .sys_rst   (sys_rst),
        .in_data   (wr_data),
        .in_valid  (wr_valid),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop)
    );

    // ********************************************************
    // synchroniser
    // ********************************************************
    // two flops on pins
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            s1_r <= '0;
            si_r <= '0;
        end else begin
            s1_r <= pin_in;
            si_r <= s1_r;
        end
    end

    // ********************************************************
    // sequence engine
    // ********************************************************
    // next state, pins, counters and events
    always_comb begin
        st_nxt   = st_r;
        po_nxt   = po_r;
        cnt_nxt  = (cnt_r != '0) ? cnt_r - 5'h01 : cnt_r;
        kind_nxt = kind_r;
        wr_nxt   = wr_r;
        cmd_nxt  = cmd_r;
        evt_nxt  = evt_r;
        ev_nxt   = 1'b0;
        fifo_pop = 1'b0;
        quiet = !(si_r.dev_sel || si_r.poll_ret || si_r.sta || po_r.poll || po_r.hold);
        po_nxt.live = live_en;
        po_nxt.supp = supp_en;
        case (st_r)
            // wait for a selection request
            ST_IDLE: begin
                if (req_valid && rdy_r) begin
                    po_nxt.bus = cio_par(req.addr);
                    cmd_nxt    = req.cmd;
                    wr_nxt     = req.write;
                    cnt_nxt    = CNT_W'(ADR_SETUP_CYC);
                    st_nxt     = ST_ADR_SET;
                end
            end
            ST_ADR_SET: begin
                if (cnt_r == '0 && quiet && gap_r >= CNT_W'(ADR_GAP_CYC) &&
                    lv_r >= CNT_W'(ADR_SETUP_CYC)) begin
                    po_nxt.adr = 1'b1;
                    cnt_nxt    = CNT_W'(POLL_DLY_CYC);
                    st_nxt     = ST_ADR_UP;
                end
            end
            // address tag up, poll not yet raised
            ST_ADR_UP: begin
                if (req_cancel) begin
                    po_nxt.adr = 1'b0;
                    st_nxt     = ST_IDLE;
                end else if (cnt_r == '0) begin
                    po_nxt.poll = 1'b1;
                    po_nxt.hold = 1'b1;
                    st_nxt      = ST_POLL;
                end
            end
            ST_POLL: begin
                if (si_r.dev_sel) begin
                    // address tag drops before the command tag
                    po_nxt.adr  = 1'b0;
                    po_nxt.poll = 1'b0;
                    po_nxt.hold = 1'b0;
                    st_nxt      = ST_SELECTED;
                end else if (si_r.poll_ret) begin
                    po_nxt.adr  = 1'b0;
                    po_nxt.poll = 1'b0;
                    po_nxt.hold = 1'b0;
                    evt_nxt     = '{code: EV_NODEV, data: 8'h00, perr: 1'b0};
                    ev_nxt      = 1'b1;
                    st_nxt      = ST_IDLE;
                end else if (si_r.sta) begin
                    // quick busy: poll drops, address stays
                    po_nxt.poll = 1'b0;
                    po_nxt.hold = 1'b0;
                    kind_nxt    = EV_BUSY;
                    cnt_nxt     = CNT_W'(IN_SETTLE_CYC);
                    st_nxt      = ST_SETTLE;
                end
            end
            // selected: serve inbound tags until deselect
            ST_SELECTED: begin
                cnt_nxt = CNT_W'(IN_SETTLE_CYC);
                if (!si_r.dev_sel) begin
                    evt_nxt = '{code: EV_END, data: 8'h00, perr: 1'b0};
                    ev_nxt  = 1'b1;
                    st_nxt  = ST_IDLE;
                end else if (si_r.adr) begin
                    kind_nxt = EV_ADDR;
                    st_nxt   = ST_SETTLE;
                end else if (si_r.sta) begin
                    kind_nxt = EV_STAT;
                    st_nxt   = ST_SETTLE;
                end else if (si_r.svc) begin
                    kind_nxt = EV_READ;
                    st_nxt   = ST_SETTLE;
                end
            end
            // let inbound lane settle, then take it
            ST_SETTLE: begin
                if (cnt_r == '0) begin
                    evt_nxt = '{code: kind_r, data: si_r.bus[7:0], perr: ~(^si_r.bus)};
                    ev_nxt  = !(kind_r == EV_READ && wr_r);
                    cnt_nxt = CNT_W'(OUT_LEAD_CYC);
                    if (kind_r == EV_BUSY) begin
                        st_nxt = ST_QB_WAIT;
                    end else if (kind_r == EV_ADDR) begin
                        po_nxt.bus = cio_par(cmd_r);
                        st_nxt     = ST_LEAD;
                    end else if (kind_r == EV_READ && wr_r) begin
                        st_nxt = ST_FETCH;
                    end else begin
                        po_nxt.bus = BUS_IDLE;
                        st_nxt     = ST_LEAD;
                    end
                end
            end
            // write data: stall until the buffer has a byte
            ST_FETCH: begin
                cnt_nxt = CNT_W'(OUT_LEAD_CYC);
                if (fifo_valid) begin
                    fifo_pop   = 1'b1;
                    po_nxt.bus = cio_par(fifo_data);
                    st_nxt     = ST_LEAD;
                end
            end
            ST_LEAD: begin
                if (cnt_r == '0) begin
                    po_nxt.cmd = (kind_r == EV_ADDR);
                    po_nxt.svc = (kind_r != EV_ADDR);
                    st_nxt     = ST_HOLD;
                end
            end
            // hold lane until inbound tag falls
            ST_HOLD: begin
                if ((kind_r == EV_ADDR && !si_r.adr) || (kind_r == EV_STAT && !si_r.sta) ||
                    (kind_r == EV_READ && !si_r.svc)) begin
                    po_nxt.cmd = 1'b0;
                    po_nxt.svc = 1'b0;
                    st_nxt     = ST_SELECTED;
                end
            end
            // quick busy: address until status falls
            ST_QB_WAIT: begin
                if (!si_r.sta) begin
                    po_nxt.adr = 1'b0;
                    st_nxt     = ST_IDLE;
                end
            end
            default: begin
                st_nxt = ST_IDLE;
            end
        endcase
        if (!live_en) begin
            po_nxt     = '{bus: BUS_IDLE, supp: supp_en, default: 1'b0};
            st_nxt     = ST_IDLE;
            fifo_pop   = 1'b0;
        end
        gap_nxt  = po_nxt.adr ? '0 : cio_inc(gap_r);
        lv_nxt   = po_nxt.live ? cio_inc(lv_r) : '0;
        stab_nxt = (po_nxt.bus != po_r.bus) ? '0 : cio_inc(stab_r);
        rdy_nxt  = (st_nxt == ST_IDLE) && live_en && !(req_valid && rdy_r);
    end

    // register the sequence group
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            st_r   <= ST_IDLE;
            po_r   <= '{bus: BUS_IDLE, default: 1'b0};
            cnt_r  <= '0;
            gap_r  <= '0;
            lv_r   <= '0;
            stab_r <= '0;
            kind_r <= EV_ADDR;
            wr_r   <= 1'b0;
            cmd_r  <= 8'h00;
            evt_r  <= '{code: EV_ADDR, data: 8'h00, perr: 1'b0};
            ev_r   <= 1'b0;
            rdy_r  <= 1'b0;
        end else begin
            st_r   <= st_nxt;
            po_r   <= po_nxt;
            cnt_r  <= cnt_nxt;
            gap_r  <= gap_nxt;
            lv_r   <= lv_nxt;
            stab_r <= stab_nxt;
            kind_r <= kind_nxt;
            wr_r   <= wr_nxt;
            cmd_r  <= cmd_nxt;
            evt_r  <= evt_nxt;
            ev_r   <= ev_nxt;
            rdy_r  <= rdy_nxt;
        end
    end

    assign pin_out   = po_r;
    assign req_ready = rdy_r;
    assign evt       = evt_r;
    assign evt_valid = ev_r;
    assign svc_req   = si_r.req;
    assign wr_ready  = fifo_in_ready;

    // ********************************************************
    // checks
    // ********************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    sequence s_adr_rise;
        !po_r.adr ##1 po_r.adr;
    endsequence

    a_cmd_lane: assert property (po_r.cmd |-> po_r.bus == cio_par(cmd_r))
        else $error("command tag up without command byte");
    a_adr_stable: assert property (po_r.adr && $past(po_r.adr) |-> $stable(po_r.bus))
        else $error("address changed while address tag up");
    a_tag_stable: assert property ((po_r.cmd || po_r.svc) |-> stab_r >= 5'h05)
        else $error("lane changed while outbound tag up");
    a_tag_lead: assert property ($rose(po_r.cmd) || $rose(po_r.svc) |-> $past(stab_r) >= 5'h04)
        else $error("outbound tag raised without 100 ns lead");
    a_adr_setup: assert property (s_adr_rise |-> $past(stab_r) >= 5'h0c && $past(gap_r) >= 5'h0d)
        else $error("address tag raised too early");
    a_adr_cancel: assert property (st_r == ST_ADR_UP && req_cancel && live_en |=> !po_r.adr)
        else $error("cancel did not drop address tag");
    a_adr_quiet: assert property (s_adr_rise |-> $past(!si_r.dev_sel && !si_r.poll_ret && !si_r.sta))
        else $error("address tag raised with selection lines busy");
    a_adr_hold: assert property ($fell(po_r.adr) && $past(po_r.poll) |->
        $past(si_r.dev_sel || si_r.poll_ret || !live_en, 1))
        else $error("address tag dropped before answer");
    a_tag_excl: assert property (!(po_r.adr && (po_r.cmd || po_r.svc)))
        else $error("address tag up with another outbound tag");
    a_odd_parity: assert property (^po_r.bus)
        else $error("outbound byte without odd parity");
endmodule : cio_chan_ctl
`default_nettype wire

// ### cio_dev_model.sv
// behavioural control unit facing the channel controller
`timescale 1ns/10ps
`default_nettype none
module cio_dev_model
    import cio_pkg::*;
#(
    parameter logic [7:0] STAT_END = 8'h0c,
    parameter logic [7:0] STAT_BUSY = 8'h10
) (
    input wire logic ref_clk,
    input wire cio_out_s pin_out,
    input wire logic [7:0] my_addr,
    input wire logic busy,
    input wire logic [5:0] n_svc,
    input wire logic want,
    input wire logic [3:0] slow,
    output var cio_in_s pin_in,
    output var logic [8:0] wr_byte,
    output var logic wr_stb
);
    cio_in_s d;          // pin values set by the sequence
    logic [8:0] last;    // last byte placed on the lane
    logic drv;           // lane driven
    // odd parity on top
    function automatic logic [8:0] par9(input logic [7:0] b);
        return {~^b, b};
    endfunction : par9
    // wait, one clock at a time, for outbound line s (0 poll, 1 cmd, 2 svc, 3 adr) to reach v
    task automatic till(input int s, input logic v);
        logic [3:0] g;
        do begin
            @(posedge ref_clk);
            #1;
            g = {pin_out.adr, pin_out.svc, pin_out.cmd, pin_out.poll};
        end while (g[s] !== v);
    endtask : till
    task automatic pause(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : pause
    // released lane shows the inverse of the last byte
    always_comb begin
        pin_in = d;
        pin_in.bus = drv ? last : ~last;
        // request drops when selected or suppressed
        pin_in.req = want & ~pin_out.supp & ~d.dev_sel;
    end
    initial begin
        d = '0;
        last = BUS_IDLE;
        drv = 0;
        wr_stb = 0;
        wr_byte = '0;
        forever begin
            till(0, 1);
            // decode only with live and address tag up
            if (!pin_out.live || !pin_out.adr) continue;
            pause(slow);
            drv = 1;
            if (pin_out.bus !== par9(my_addr)) begin
                drv = 0;
                d.poll_ret = 1;
                till(0, 0);
                d.poll_ret = 0;
            end else if (busy) begin
                // busy status held past the poll fall
                last = par9(STAT_BUSY);
                d.sta = 1;
                till(0, 0);
                pause(8 + slow);
                d.sta = 0;
                till(3, 0);
            end else begin
                // address echo, service bytes, then status
                last = par9(my_addr);
                d.dev_sel = 1;
                d.adr = 1;
                till(1, 1);
                d.adr = 0;
                till(1, 0);
                for (int k = 0; k <= n_svc; k++) begin
                    pause(slow);
                    last = par9(k == n_svc ? STAT_END : 8'(my_addr + k));
                    d.sta = (k == n_svc);
                    d.svc = (k != n_svc);
                    till(2, 1);
                    wr_byte = pin_out.bus;
                    wr_stb = d.svc;
                    d.sta = 0;
                    d.svc = 0;
                    till(2, 0);
                    wr_stb = 0;
                end
                d.dev_sel = 0;
            end
            drv = 0;
        end
    end
endmodule : cio_dev_model
`default_nettype wire

// ### tb_top.sv
// self-checking bench for the channel-side tag controller
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import cio_pkg::*;
;
    localparam logic [7:0] STAT_END = 8'h0c;
    localparam logic [7:0] STAT_BUSY = 8'h10;
    logic ref_clk = 0, sys_rst = 1, live_en = 0, supp_en = 0, want = 0, busy = 0;
    logic req_valid = 0, req_cancel = 0, wr_valid = 0, req_ready, wr_ready, evt_valid, svc_req, wr_stb;
    logic [7:0] wr_data = '0, my_addr = '0;
    logic [5:0] n_svc = '0;
    logic [3:0] slow = '0;
    logic [8:0] wr_byte;
    cio_req_s req = '0;
    cio_evt_s evt;
    cio_in_s pin_in;
    cio_out_s pin_out, prev = '0;
    int fail_count = 0, checks_done = 0, seed = 45, cycles = 0, lead = 0, t;
    logic [15:0] exp_evt[$], exp_wr[$], e;
    always #10 ref_clk = ~ref_clk;
    cio_chan_ctl uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .live_en(live_en), .supp_en(supp_en), .req(req),
        .req_valid(req_valid), .req_ready(req_ready), .req_cancel(req_cancel), .wr_data(wr_data),
        .wr_valid(wr_valid), .wr_ready(wr_ready), .evt(evt), .evt_valid(evt_valid), .svc_req(svc_req),
        .pin_in(pin_in), .pin_out(pin_out));
    cio_dev_model #(.STAT_END(STAT_END), .STAT_BUSY(STAT_BUSY)) dev (.ref_clk(ref_clk), .pin_out(pin_out),
        .my_addr(my_addr), .busy(busy), .n_svc(n_svc), .want(want), .slow(slow), .pin_in(pin_in),
        .wr_byte(wr_byte), .wr_stb(wr_stb));
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : summarize
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick
    // one request, raised for one cycle once ready is seen high
    task automatic send();
        t = 0;
        while (req_ready !== 1'b1 && t < 500) begin tick(1); t++; end
        req_valid = 1;
        tick(1);
        req_valid = 0;
    endtask : send
    // one selection sequence; expected events queued from the model rules
    task automatic run(input logic present, input logic b, input logic wr, input int n);
        my_addr = $random(seed);
        slow = $random(seed);
        busy = b;
        n_svc = 6'(n);
        req = '{addr: present ? my_addr : ~my_addr, cmd: 8'($random(seed)), write: wr};
        if (!present) exp_evt.push_back(16'h0400);
        else if (b) exp_evt.push_back({8'h03, STAT_BUSY});
        else begin
            exp_evt.push_back({8'h00, my_addr});
            for (int k = 0; k < n && !wr; k++) exp_evt.push_back({8'h02, 8'(my_addr + k)});
            exp_evt.push_back({8'h01, STAT_END});
            exp_evt.push_back(16'h0500);
        end
        send();
        t = 0;
        while ((exp_evt.size() + exp_wr.size() > 0 || req_ready !== 1'b1) && t < 4000) begin tick(1); t++; end
        check(16'(exp_evt.size() + exp_wr.size()), 16'h0);
        $display("test done present %0d busy %0d write %0d bytes %0d", present, b, wr, n);
    endtask : run
    // timeout, event compare, lane lead and tag overlap; sampled mid-cycle where outputs are settled
    always @(negedge ref_clk) begin
        cycles++;
        if (cycles > 60000) begin
            fail_count++;
            summarize();
        end else begin
            if (evt_valid === 1'b1) begin
                e = exp_evt.size() ? exp_evt.pop_front() : 16'hffff;
                check({evt.perr, 4'h0, evt.code, evt.data}, e);
            end
            if (pin_out.cmd && !prev.cmd || pin_out.svc && !prev.svc) check(16'(lead > 3), 16'h1);
            if (pin_out.adr && !prev.adr) check(16'({lead > 11, pin_out.poll | pin_in.dev_sel}), 16'h2);
            if (pin_out.adr && (pin_out.cmd || pin_out.svc)) check(16'h1, 16'h0);
            lead <= (pin_out.bus == prev.bus) ? lead + 1 : 0;
            prev <= pin_out;
        end
    end
    // bytes the device took on an outbound service tag
    always @(posedge wr_stb) if (req.write) check({7'h0, wr_byte}, exp_wr.size() ? exp_wr.pop_front() : 16'hffff);
    initial begin
        tick(2);
        check(pin_out, {BUS_IDLE, 7'h00});
        tick(3);
        sys_rst = 0;
        live_en = 1;
        want = 1;
        tick(6);
        check(16'({svc_req, pin_out.supp}), 16'h2);
        supp_en = 1;
        tick(6);
        check(16'({svc_req, pin_out.supp}), 16'h1);
        supp_en = 0;
        run(1, 0, 0, 0);
        run(1, 0, 0, 3);
        run(0, 0, 0, 0);
        run(1, 1, 0, 0);
        repeat (4) run($random(seed) % 4 != 0, $random(seed) % 3 == 0, 0, $random(seed) & 3);
        t = 0;
        while (wr_ready === 1'b1 && t < 40) begin
            wr_data = $random(seed);
            exp_wr.push_back({7'h0, ~^wr_data, wr_data});
            wr_valid = 1;
            tick(1);
            t++;
        end
        wr_valid = 0;
        check(16'(t), 16'h20);
        run(1, 0, 1, 32);
        for (int v = 0; v < 2; v++) begin
            req = '{addr: 8'h5a, cmd: 8'h00, write: 1'b0};
            my_addr = 8'h5a;
            send();
            t = 0;
            while (pin_out.adr !== 1'b1 && t < 100) begin tick(1); t++; end
            if (v == 0) req_cancel = 1;
            else live_en = 0;
            tick(3);
            check(16'({pin_out.adr, pin_out.poll, pin_out.hold, pin_out.live}), v ? 16'h0 : 16'h1);
            req_cancel = 0;
            live_en = 1;
            $display("test done withdraw %0d", v);
        end
        want = 0;
        tick(50);
        check(16'({req_ready, svc_req}), 16'h2);
        summarize();
    end
endmodule : tb_top
`default_nettype wire
